// [acq_front_end.sv]
`timescale 1ns/1ps
`include "acq_fe_cfg.svh"
module acq_front_end (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// deserialized camera link
	input wire logic pix_clk,
	input wire logic [23:0] cam_data,
	input wire logic cam_fval,
	input wire logic cam_lval,
	input wire logic cam_dval,
	input wire logic cam_spare,
	// external triggers
	input wire logic [3:0] single_ended_trigger_line_in,
	output logic [3:0] single_ended_trigger_line_out,
	output logic [3:0] single_ended_trigger_line_oe,
	input wire logic [1:0] iso_trigger_input,
	input wire logic [1:0] differential_trigger_input,
	// inter-board bus triggers
	input wire logic [3:0] bus_trig_in,
	output logic [3:0] bus_trig_out,
	output logic [3:0] bus_trig_oe,
	// camera control lines 1-4
	output logic [3:0] cam_ctrl,
	// sdram fifo write side
	output logic mem_wr_valid,
	output logic [23:0] mem_wr_data,
	output logic [15:0] mem_wr_x,
	output logic [15:0] mem_wr_y,
	output logic [1:0] mem_wr_tap,
	input wire logic mem_drain
);
	acq_fe_pkg::state_t q;
	acq_fe_pkg::state_t d;
	acq_fe_pkg::pin_t s;
	acq_fe_pkg::pix_fmt_t fmt;
	logic wr;
	logic ctrl_wr;
	logic mapped;
	logic [31:0] rv;
	logic pix_ev;
	logic fv_rise;
	logic fv_fall;
	logic lv_rise;
	logic beat_ok;
	logic in_win;
	logic [15:0] idx;
	logic [15:0] lc;
	logic [15:0] cur_ln;
	logic [15:0] rx;
	logic [15:0] ry;
	logic [7:0] tin;
	logic [7:0] tev;
	logic trg_start;
	logic sw_start;
	logic [4:0] step;
	logic [4:0] sh;
	logic [1:0] last_tap;
	logic [23:0] white;
	logic [23:0] v;
	logic [23:0] cap;
	logic [15:0] seg;
	logic [15:0] base;
	logic in_thr;
	logic bin_on;
	logic full;
	logic [1:0] src;
	logic lvl;

	assign s = q.sync;
	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign single_ended_trigger_line_out = q.se_out;
	assign single_ended_trigger_line_oe = q.se_oe;
	assign bus_trig_out = q.bus_out;
	assign bus_trig_oe = q.bus_oe;
	assign cam_ctrl = q.cc;
	assign mem_wr_valid = q.mvalid;
	assign mem_wr_data = q.mdata;
	assign mem_wr_x = q.mx;
	assign mem_wr_y = q.my;
	assign mem_wr_tap = q.mtap;

	always_comb begin
		d = q;
		wr = psel & penable & pwrite;
		// link bits enter via two flops
		d.meta = {pix_clk, cam_fval, cam_lval, cam_dval, cam_spare,
			cam_data, single_ended_trigger_line_in, iso_trigger_input,
			differential_trigger_input, bus_trig_in};
		d.sync = q.meta;
		// settled before the status read below uses them
		// eight trigger lines with polarity
		for (int i = 0; i < 8; i++) begin
			if (i < 4) begin
				if (q.trgcfg[`TC_SE + i])
					lvl = s.se[i];
				else if (i < 2)
					lvl = s.iso[i];
				else
					lvl = s.diff[i - 2];
			end else begin
				lvl = s.bus[i - 4];
			end
			tin[i] = lvl ^ q.trgcfg[`TC_POL + i];
		end
		cap = q.ctrl[`C_MEM32] ? `MEM_WORDS_32MB : `MEM_WORDS_16MB;
		full = (q.occ + 24'(q.mvalid)) >= cap;
		mapped = 1'b1;
		rv = 32'h0;
		if (paddr == `A_CTRL) begin
			rv = {24'h0, q.ctrl};
			if (wr)
				d.ctrl = pwdata[7:0] & `CTRL_KEEP;
		end else if (paddr == `A_STAT) begin
			rv = {q.done_cnt, tin, 3'h0, q.trig_arm, q.ovf, full,
				q.frame_on, q.acq};
		end else if (paddr == `A_HWIN) begin
			rv = q.hwin;
			if (wr)
				d.hwin = pwdata;
		end else if (paddr == `A_VWIN) begin
			rv = q.vwin;
			if (wr)
				d.vwin = pwdata;
		end else if (paddr == `A_HROI) begin
			rv = q.hroi;
			if (wr)
				d.hroi = pwdata;
		end else if (paddr == `A_VROI) begin
			rv = q.vroi;
			if (wr)
				d.vroi = pwdata;
		end else if (paddr == `A_THR) begin
			rv = q.thr;
			if (wr)
				d.thr = pwdata;
		end else if (paddr == `A_FMT) begin
			rv = q.fmt;
			if (wr)
				d.fmt = pwdata;
		end else if (paddr == `A_TAPDIR) begin
			rv = q.tapdir;
			if (wr)
				d.tapdir = pwdata;
		end else if (paddr == `A_FRAMES) begin
			rv = q.frames;
			if (wr)
				d.frames = pwdata;
		end else if (paddr == `A_TRGCFG) begin
			rv = q.trgcfg;
			if (wr)
				d.trgcfg = pwdata;
		end else if (paddr == `A_TRGSRC) begin
			rv = q.trgsrc;
			if (wr)
				d.trgsrc = pwdata;
		end else if (paddr == `A_PULSE1) begin
			rv = q.pulse1;
			if (wr)
				d.pulse1 = pwdata;
		end else if (paddr == `A_PULSE2) begin
			rv = q.pulse2;
			if (wr)
				d.pulse2 = pwdata;
		end else if (paddr == `A_CCSEL) begin
			rv = q.ccsel;
			if (wr)
				d.ccsel = pwdata;
		end else if (paddr == `A_OCC) begin
			rv = {8'h0, q.occ};
		end else begin
			mapped = 1'b0;
		end
		// read data captured in setup, shown in access
		if (psel & ~penable)
			d.rdata = rv;
		ctrl_wr = wr && (paddr == `A_CTRL);
		sw_start = ctrl_wr & pwdata[`C_START];

		tev = (q.trgcfg[`TC_EDGE +: 8] & q.trg_prev & ~tin) |
			(~q.trgcfg[`TC_EDGE +: 8] & ~q.trg_prev & tin);
		d.trg_prev = tin;
		trg_start = q.trig_arm && ((tev & q.trgsrc[`TS_MASK +: 8]) != 8'h0);
		if (ctrl_wr & pwdata[`C_ARM])
			d.trig_arm = 1'b1;

		case (q.pst)
			acq_fe_pkg::p_idle: begin
				if (ctrl_wr & pwdata[`C_PGO]) begin
					d.pst = acq_fe_pkg::p_delay;
					d.ptmr = q.pulse1[`F_LO];
					d.pcnt = q.pulse2[`F_HI];
				end
			end
			acq_fe_pkg::p_delay: begin
				d.ptmr = q.ptmr - 16'h1;
				if (q.ptmr <= 16'h1) begin
					d.pst = acq_fe_pkg::p_high;
					d.ptmr = q.pulse1[`F_HI];
				end
			end
			acq_fe_pkg::p_high: begin
				d.ptmr = q.ptmr - 16'h1;
				if (q.ptmr <= 16'h1) begin
					// zero count runs the train until stopped
					if (q.pcnt == 16'h1) begin
						d.pst = acq_fe_pkg::p_idle;
					end else begin
						d.pst = acq_fe_pkg::p_low;
						d.ptmr = 16'(q.pulse2[`F_LO] - q.pulse1[`F_HI]);
					end
					if (q.pcnt != 16'h0)
						d.pcnt = q.pcnt - 16'h1;
				end
			end
			acq_fe_pkg::p_low: begin
				d.ptmr = q.ptmr - 16'h1;
				if (q.ptmr <= 16'h1 || q.ptmr > q.pulse2[`F_LO]) begin
					d.pst = acq_fe_pkg::p_high;
					d.ptmr = q.pulse1[`F_HI];
				end
			end
			default: d.pst = acq_fe_pkg::p_idle;
		endcase
		if (ctrl_wr & pwdata[`C_PSTOP])
			d.pst = acq_fe_pkg::p_idle;
		d.pout = (d.pst == acq_fe_pkg::p_high);

		for (int i = 0; i < 8; i++) begin
			src = q.trgsrc[2 * i +: 2];
			if (src == `SRC_LEVEL)
				lvl = q.trgsrc[`TS_LVL + i];
			else if (src == `SRC_PULSE)
				lvl = q.pout;
			else if (src == `SRC_ACQ)
				lvl = q.acq;
			else
				lvl = q.frame_on;
			lvl = lvl ^ q.trgcfg[`TC_POL + i];
			if (i < 4) begin
				d.se_out[i] = lvl;
				d.se_oe[i] = q.trgcfg[`TC_DIR + i] & q.trgcfg[`TC_SE + i];
			end else begin
				d.bus_out[i - 4] = lvl;
				d.bus_oe[i - 4] = q.trgcfg[`TC_DIR + i];
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (q.ccsel[`CC_EXT + i])
				d.cc[i] = tin[i];
			else if (q.ccsel[`CC_PULSE + i])
				d.cc[i] = q.pout;
			else
				d.cc[i] = q.ccsel[`CC_LVL + i];
		end

		// enables sampled at pixel clock rise
		pix_ev = s.pclk & ~q.pclk_d;
		d.pclk_d = s.pclk;
		fv_rise = pix_ev & s.fval & ~q.fval_d;
		fv_fall = pix_ev & ~s.fval & q.fval_d;
		lv_rise = pix_ev & s.lval & ~q.lval_d;
		if (pix_ev) begin
			d.fval_d = s.fval;
			d.lval_d = s.lval;
		end
		// lines counted from frame enable edge
		lc = fv_rise ? 16'h0 : q.lcnt;
		if (fv_rise)
			d.lcnt = 16'h0;
		if (lv_rise & s.fval) begin
			d.ln = lc;
			d.lcnt = lc + 16'h1;
		end
		cur_ln = (lv_rise & s.fval) ? lc : q.ln;
		// pixels counted from line enable edge
		idx = lv_rise ? 16'h0 : q.px;
		// all three enables qualify a beat
		beat_ok = pix_ev & s.fval & s.lval & s.dval;
		if (beat_ok)
			d.px = idx + 16'h1;
		else if (lv_rise)
			d.px = 16'h0;
		rx = 16'(idx - q.hwin[`F_LO]);
		ry = 16'(cur_ln - q.vwin[`F_LO]);
		in_win = idx >= q.hwin[`F_LO] && rx < q.hwin[`F_HI] &&
			cur_ln >= q.vwin[`F_LO] && ry < q.vwin[`F_HI] &&
			rx >= q.hroi[`F_LO] &&
			16'(rx - q.hroi[`F_LO]) < q.hroi[`F_HI] &&
			ry >= q.vroi[`F_LO] &&
			16'(ry - q.vroi[`F_LO]) < q.vroi[`F_HI];

		if (fv_rise & q.acq) begin
			d.frame_on = (q.skip_cnt == 16'h0);
			if (q.skip_cnt != 16'h0)
				d.skip_cnt = q.skip_cnt - 16'h1;
		end
		if (fv_fall & q.frame_on) begin
			d.frame_on = 1'b0;
			d.done_cnt = q.done_cnt + 16'h1;
			if (q.frames[`F_HI] != 16'h0 &&
					q.done_cnt + 16'h1 == q.frames[`F_HI])
				d.acq = 1'b0;
		end
		if (sw_start | trg_start) begin
			d.acq = 1'b1;
			d.trig_arm = 1'b0;
			d.frame_on = 1'b0;
			d.skip_cnt = q.frames[`F_LO];
			d.done_cnt = 16'h0;
			d.ovf = 1'b0;
		end
		if (ctrl_wr & pwdata[`C_STOP]) begin
			d.acq = 1'b0;
			d.frame_on = 1'b0;
			d.trig_arm = 1'b0;
		end

		fmt = acq_fe_pkg::pix_fmt_t'(q.fmt[3:0]);
		step = `STEP_8;
		last_tap = 2'h0;
		white = `WHITE_8;
		case (fmt)
			acq_fe_pkg::fmt_8x2: last_tap = 2'h1;
			acq_fe_pkg::fmt_8x3: last_tap = 2'h2;
			acq_fe_pkg::fmt_10x1: white = `WHITE_10;
			acq_fe_pkg::fmt_10x2: begin
				white = `WHITE_10;
				step = `STEP_12;
				last_tap = 2'h1;
			end
			acq_fe_pkg::fmt_12x1: white = `WHITE_12;
			acq_fe_pkg::fmt_12x2: begin
				white = `WHITE_12;
				step = `STEP_12;
				last_tap = 2'h1;
			end
			acq_fe_pkg::fmt_14x1: white = `WHITE_14;
			acq_fe_pkg::fmt_16x1: white = `WHITE_16;
			acq_fe_pkg::fmt_rgb: white = `WHITE_24;
			default: white = `WHITE_8;
		endcase

		// only windowed beats of a captured frame
		if (beat_ok & q.frame_on & in_win & ~q.busy) begin
			d.busy = 1'b1;
			d.tap = 2'h0;
			d.beat = s.data;
			d.col = 16'(rx - q.hroi[`F_LO]);
			d.row = 16'(ry - q.vroi[`F_LO]);
		end

		if (q.tap == 2'h0)
			sh = 5'h0;
		else if (q.tap == 2'h1)
			sh = step;
		else
			sh = 5'(step << 1);
		v = (q.beat >> sh) & white;
		in_thr = v >= {8'h0, q.thr[`F_LO]} && v <= {8'h0, q.thr[`F_HI]};
		bin_on = (fmt != acq_fe_pkg::fmt_rgb) &&
			(q.ctrl[`C_BIN] | q.ctrl[`C_INV]);
		seg = q.tapdir[`F_HI];
		if (q.tap == 2'h0)
			base = 16'h0;
		else if (q.tap == 2'h1)
			base = seg;
		else
			base = 16'(seg << 1);

		d.occ = 24'(q.occ + 24'(q.mvalid) -
			24'(mem_drain && q.occ != 24'h0));
		d.mvalid = 1'b0;
		if (q.busy) begin
			if (full) begin
				d.ovf = 1'b1;
			end else begin
				d.mvalid = 1'b1;
				if (!bin_on)
					d.mdata = v;
				else if (in_thr ^ q.ctrl[`C_INV])
					d.mdata = white;
				else
					d.mdata = 24'h0;
				if (q.tapdir[`TD_H + q.tap])
					d.mx = 16'(base + seg - 16'h1 - q.col);
				else
					d.mx = 16'(base + q.col);
				if (q.tapdir[`TD_V + q.tap])
					d.my = 16'(q.vroi[`F_HI] - 16'h1 - q.row);
				else
					d.my = q.row;
				d.mtap = q.tap;
			end
			d.tap = q.tap + 2'h1;
			if (q.tap >= last_tap)
				d.busy = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end
endmodule : acq_front_end

// [acq_fe_cfg.svh]
`ifndef ACQ_FE_CFG_SVH
`define ACQ_FE_CFG_SVH
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_HWIN 12'h008
`define A_VWIN 12'h00C
`define A_HROI 12'h010
`define A_VROI 12'h014
`define A_THR 12'h018
`define A_FMT 12'h01C
`define A_TAPDIR 12'h020
`define A_FRAMES 12'h024
`define A_TRGCFG 12'h028
`define A_TRGSRC 12'h02C
`define A_PULSE1 12'h030
`define A_PULSE2 12'h034
`define A_CCSEL 12'h038
`define A_OCC 12'h03C
`define F_LO 15:0
`define F_HI 31:16
`define C_START 0
`define C_STOP 1
`define C_BIN 2
`define C_INV 3
`define C_MEM32 4
`define C_ARM 5
`define C_PGO 6
`define C_PSTOP 7
`define CTRL_KEEP 8'h1C
`define TD_H 0
`define TD_V 4
`define TC_EDGE 0
`define TC_POL 8
`define TC_DIR 16
`define TC_SE 24
`define TS_LVL 16
`define TS_MASK 24
`define CC_EXT 0
`define CC_PULSE 4
`define CC_LVL 8
`define SRC_LEVEL 2'h0
`define SRC_PULSE 2'h1
`define SRC_ACQ 2'h2
`define MEM_WORDS_16MB 24'h400000
`define MEM_WORDS_32MB 24'h800000
`define STEP_8 5'h08
`define STEP_12 5'h0C
`define WHITE_8 24'h0000FF
`define WHITE_10 24'h0003FF
`define WHITE_12 24'h000FFF
`define WHITE_14 24'h003FFF
`define WHITE_16 24'h00FFFF
`define WHITE_24 24'hFFFFFF
`endif

// [acq_fe_pkg.sv]
package acq_fe_pkg;
	typedef enum logic [3:0] {
		fmt_8x1 = 4'h0, fmt_8x2 = 4'h1, fmt_8x3 = 4'h2,
		fmt_10x1 = 4'h3, fmt_10x2 = 4'h4, fmt_12x1 = 4'h5,
		fmt_12x2 = 4'h6, fmt_14x1 = 4'h7, fmt_16x1 = 4'h8,
		fmt_rgb = 4'h9
	} pix_fmt_t;
	typedef enum logic [1:0] {
		p_idle = 2'h0, p_delay = 2'h1, p_high = 2'h2, p_low = 2'h3
	} pulse_state_t;
	typedef struct packed {
		logic pclk;
		logic fval;
		logic lval;
		logic dval;
		logic spare;
		logic [23:0] data;
		logic [3:0] se;
		logic [1:0] iso;
		logic [1:0] diff;
		logic [3:0] bus;
	} pin_t;
	typedef struct packed {
		pin_t meta;
		pin_t sync;
		logic pclk_d;
		logic fval_d;
		logic lval_d;
		logic [7:0] trg_prev;
		logic [7:0] ctrl;
		logic [31:0] hwin;
		logic [31:0] vwin;
		logic [31:0] hroi;
		logic [31:0] vroi;
		logic [31:0] thr;
		logic [31:0] fmt;
		logic [31:0] tapdir;
		logic [31:0] frames;
		logic [31:0] trgcfg;
		logic [31:0] trgsrc;
		logic [31:0] pulse1;
		logic [31:0] pulse2;
		logic [31:0] ccsel;
		logic [31:0] rdata;
		logic acq;
		logic trig_arm;
		logic frame_on;
		logic ovf;
		logic [15:0] skip_cnt;
		logic [15:0] done_cnt;
		logic [15:0] px;
		logic [15:0] lcnt;
		logic [15:0] ln;
		logic busy;
		logic [1:0] tap;
		logic [23:0] beat;
		logic [15:0] col;
		logic [15:0] row;
		logic mvalid;
		logic [23:0] mdata;
		logic [15:0] mx;
		logic [15:0] my;
		logic [1:0] mtap;
		logic [23:0] occ;
		pulse_state_t pst;
		logic [15:0] ptmr;
		logic [15:0] pcnt;
		logic pout;
		logic [3:0] se_out;
		logic [3:0] se_oe;
		logic [3:0] bus_out;
		logic [3:0] bus_oe;
		logic [3:0] cc;
	} state_t;
endpackage : acq_fe_pkg

// [acq_fe_properties.sv]
`timescale 1ns/1ps
module acq_fe_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// camera link
	input wire logic cam_fval,
	input wire logic cam_lval,
	input wire logic cam_dval,
	// fifo write side
	input wire logic mem_wr_valid,
	input wire logic [23:0] mem_wr_data,
	input wire logic [15:0] mem_wr_x,
	input wire logic [15:0] mem_wr_y,
	input wire logic [1:0] mem_wr_tap
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cycles since the link last showed a full beat
	logic [4:0] age_q;
	logic [4:0] age_d;
	always_comb begin
		age_d = age_q;
		if (cam_fval && cam_lval && cam_dval)
			age_d = 5'h00;
		else if (age_q != 5'h1F)
			age_d = age_q + 5'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_q <= 5'h1F;
		else
			age_q <= age_d;
	end
	sequence access_s;
		psel && penable;
	endsequence
	apb_ready_a: assert property (access_s |-> pready)
		else $error("access phase without ready");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	err_mapped_a: assert property (access_s |->
		(paddr >= 12'h040) == pslverr)
		else $error("error flag does not match address map");
	err_data_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read returns data");
	word_cause_a: assert property (
		mem_wr_valid |-> age_q < 5'h0C)
		else $error("word written without a beat");
	word_hold_a: assert property (
		!mem_wr_valid |-> $stable(mem_wr_data))
		else $error("word data moved without a write");
	pos_hold_a: assert property (
		!mem_wr_valid |-> $stable({mem_wr_x, mem_wr_y, mem_wr_tap}))
		else $error("word position moved without a write");
	tap_range_a: assert property (
		mem_wr_valid |-> mem_wr_tap != 2'h3)
		else $error("tap index beyond three taps");
endmodule : acq_fe_properties

bind acq_front_end acq_fe_properties acq_fe_properties_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cam_fval(cam_fval), .cam_lval(cam_lval), .cam_dval(cam_dval),
	.mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
	.mem_wr_x(mem_wr_x), .mem_wr_y(mem_wr_y), .mem_wr_tap(mem_wr_tap)
);

// [cam_model.sv]
`timescale 1ns/1ps
module cam_model (
	// camera link
	output logic pix_clk,
	output logic [23:0] cam_data,
	output logic cam_fval,
	output logic cam_lval,
	output logic cam_dval,
	output logic cam_spare
);
	initial begin
		pix_clk = 1'b0;
		cam_data = 24'h000000;
		cam_fval = 1'b0;
		cam_lval = 1'b0;
		cam_dval = 1'b0;
		cam_spare = 1'b0;
	end
	task automatic tick();
		#80 pix_clk = 1'b1;
		#80 pix_clk = 1'b0;
	endtask : tick
	// idle data scrambled so a stale word never looks valid
	task automatic gap();
		cam_dval = 1'b0;
		cam_data = ~cam_data;
		tick();
	endtask : gap
	// data and enables move after the falling edge
	task automatic frame(input int lines, input int pix);
		cam_fval = 1'b1;
		gap();
		for (int l = 0; l < lines; l++) begin
			cam_lval = 1'b1;
			gap();
			for (int p = 0; p < pix; p++) begin
				cam_dval = 1'b1;
				cam_data = 24'(16 + 4 * l + p);
				tick();
				if (p == 1)
					gap();
			end
			cam_lval = 1'b0;
			gap();
		end
		cam_fval = 1'b0;
		gap();
		gap();
	endtask : frame
endmodule : cam_model

// [camera_link_acquisition_front_end_tb_top.sv]
`timescale 1ns/1ps
`include "acq_fe_cfg.svh"
module camera_link_acquisition_front_end_tb_top;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pix_clk;
	logic [23:0] cam_data;
	logic cam_fval;
	logic cam_lval;
	logic cam_dval;
	logic cam_spare;
	logic [3:0] se_in;
	logic [3:0] se_out;
	logic [3:0] se_oe;
	logic [1:0] iso_in;
	logic [3:0] bus_out;
	logic [3:0] bus_oe;
	logic [3:0] cam_ctrl;
	logic mem_wr_valid;
	logic [23:0] mem_wr_data;
	logic [15:0] mem_wr_x;
	logic [15:0] mem_wr_y;
	logic [1:0] mem_wr_tap;
	logic [1:0] diff_in;
	logic [3:0] bus_in;
	logic mem_drain;
	logic [23:0] got[$];
	logic [31:0] pos[$];
	logic [1:0] tp[$];
	int fails;
	int comparisons;
	acq_front_end acq_front_end_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pix_clk(pix_clk), .cam_data(cam_data), .cam_fval(cam_fval),
		.cam_lval(cam_lval), .cam_dval(cam_dval), .cam_spare(cam_spare),
		.single_ended_trigger_line_in(se_in),
		.single_ended_trigger_line_out(se_out),
		.single_ended_trigger_line_oe(se_oe),
		.iso_trigger_input(iso_in), .differential_trigger_input(diff_in),
		.bus_trig_in(bus_in), .bus_trig_out(bus_out), .bus_trig_oe(bus_oe),
		.cam_ctrl(cam_ctrl), .mem_wr_valid(mem_wr_valid),
		.mem_wr_data(mem_wr_data), .mem_wr_x(mem_wr_x),
		.mem_wr_y(mem_wr_y), .mem_wr_tap(mem_wr_tap),
		.mem_drain(mem_drain)
	);
	cam_model cam_model_inst (
		.pix_clk(pix_clk), .cam_data(cam_data), .cam_fval(cam_fval),
		.cam_lval(cam_lval), .cam_dval(cam_dval), .cam_spare(cam_spare)
	);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (mem_wr_valid === 1'b1) begin
			got.push_back(mem_wr_data);
			pos.push_back({mem_wr_y, mem_wr_x});
			tp.push_back(mem_wr_tap);
		end
	end
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] seen);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			print_verdict();
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] r,
			output logic e);
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd
	task automatic regs_scn();
		logic [31:0] r;
		logic e;
		rd(`A_HWIN, r, e);
		check("hwin reset", 32'h0, r);
		wr(`A_HWIN, 32'h0002_0001);
		rd(`A_HWIN, r, e);
		check("hwin", 32'h0002_0001, r);
		wr(`A_STAT, 32'hFFFF_FFFF);
		rd(`A_STAT, r, e);
		check("stat", 32'h0, r);
		rd(12'h040, r, e);
		check("unmapped err", 32'h1, {31'h0, e});
		check("unmapped data", 32'h0, r);
	endtask : regs_scn
	task automatic frame_scn(input logic [31:0] ctrl,
			input logic [23:0] e0, input logic [23:0] e1);
		int n;
		got.delete();
		pos.delete();
		tp.delete();
		wr(`A_CTRL, ctrl | 32'h1);
		cam_model_inst.frame(3, 4);
		n = 0;
		while (got.size() < 2 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		repeat (20) @(posedge pclk);
		check("words", 32'h2, 32'(got.size()));
		if (got.size() != 2)
			print_verdict();
		check("word0", {8'h0, e0}, {8'h0, got[0]});
		check("word1", {8'h0, e1}, {8'h0, got[1]});
		check("pos0", 32'h0000_0000, pos[0]);
		check("pos1", 32'h0001_0000, pos[1]);
		wr(`A_CTRL, 32'h2);
	endtask : frame_scn
	task automatic trig_scn();
		wr(`A_TRGSRC, 32'h0011_0000);
		wr(`A_TRGCFG, 32'h0111_0000);
		repeat (2) @(posedge pclk);
		check("se out", 32'h1, {28'h0, se_out});
		check("se oe", 32'h1, {28'h0, se_oe});
		check("bus out", 32'h1, {28'h0, bus_out});
		check("bus oe", 32'h1, {28'h0, bus_oe});
		wr(`A_TRGCFG, 32'h0011_0000);
		repeat (2) @(posedge pclk);
		check("se oe off", 32'h0, {28'h0, se_oe});
	endtask : trig_scn
	task automatic ctrl_scn();
		wr(`A_TRGCFG, 32'h0100_0000);
		wr(`A_CCSEL, 32'h0000_0001);
		se_in <= 4'h1;
		repeat (8) @(posedge pclk);
		check("ctrl line", 32'h1, {28'h0, cam_ctrl});
		wr(`A_TRGCFG, 32'h0);
		se_in <= 4'h0;
		iso_in <= 2'h1;
		repeat (8) @(posedge pclk);
		check("ctrl iso", 32'h1, {28'h0, cam_ctrl});
		iso_in <= 2'h0;
		repeat (8) @(posedge pclk);
		check("ctrl low", 32'h0, {28'h0, cam_ctrl});
	endtask : ctrl_scn
	task automatic wait_words(input int k);
		int n;
		n = 0;
		while (got.size() < k && n < 100) begin
			@(posedge pclk);
			n++;
		end
		repeat (20) @(posedge pclk);
	endtask : wait_words
	task automatic tap_scn();
		logic [31:0] r;
		logic e;
		logic [3:0][23:0] ed;
		logic [3:0][31:0] ep;
		ed = {24'h000000, 24'h00001A, 24'h000000, 24'h000016};
		ep = {32'h0001_0007, 32'h0000_0000, 32'h0000_0007, 32'h0001_0000};
		wr(`A_FMT, 32'h1);
		wr(`A_TAPDIR, 32'h0004_0012);
		got.delete();
		pos.delete();
		tp.delete();
		wr(`A_CTRL, 32'h1);
		cam_model_inst.frame(3, 4);
		wait_words(4);
		check("tap words", 32'h4, 32'(got.size()));
		if (got.size() != 4)
			print_verdict();
		for (int i = 0; i < 4; i++) begin
			check("tap data", {8'h0, ed[i]}, {8'h0, got[i]});
			check("tap pos", ep[i], pos[i]);
			check("tap index", 32'(i % 2), {30'h0, tp[i]});
		end
		wr(`A_CTRL, 32'h2);
		wr(`A_FMT, 32'h0);
		wr(`A_TAPDIR, 32'h0);
		rd(`A_OCC, r, e);
		check("fill", 32'h0000_000A, r);
		mem_drain <= 1'b1;
		@(posedge pclk);
		mem_drain <= 1'b0;
		rd(`A_OCC, r, e);
		check("drained fill", 32'h0000_0009, r);
	endtask : tap_scn
	task automatic trig_start_scn();
		logic [31:0] r;
		logic e;
		wr(`A_TRGCFG, 32'h0000_0004);
		wr(`A_TRGSRC, 32'h0400_0000);
		wr(`A_FRAMES, 32'h0001_0001);
		diff_in <= 2'h1;
		bus_in <= 4'h1;
		repeat (8) @(posedge pclk);
		wr(`A_CTRL, 32'h20);
		rd(`A_STAT, r, e);
		check("armed", 32'h0000_1410, r & 32'h0000_FF1F);
		diff_in <= 2'h0;
		bus_in <= 4'h0;
		repeat (8) @(posedge pclk);
		rd(`A_STAT, r, e);
		check("started", 32'h0000_0001, r & 32'h0000_FF1F);
		got.delete();
		pos.delete();
		tp.delete();
		cam_model_inst.frame(3, 4);
		check("skipped", 32'h0, 32'(got.size()));
		cam_model_inst.frame(3, 4);
		wait_words(2);
		check("limit words", 32'h2, 32'(got.size()));
		rd(`A_STAT, r, e);
		check("limit stop", 32'h0001_0000, r & 32'hFFFF_001F);
		wr(`A_FRAMES, 32'h0);
		wr(`A_TRGCFG, 32'h0);
		wr(`A_TRGSRC, 32'h0);
	endtask : trig_start_scn
	task automatic pulse_scn();
		int n;
		wr(`A_PULSE1, 32'h0004_0003);
		wr(`A_PULSE2, 32'h0002_000A);
		wr(`A_CCSEL, 32'h0000_0010);
		wr(`A_CTRL, 32'h40);
		n = 0;
		repeat (40) begin
			@(posedge pclk);
			if (cam_ctrl[0] === 1'b1)
				n++;
		end
		check("pulse cycles", 32'h8, 32'(n));
		check("pulse end", 32'h0, {28'h0, cam_ctrl});
	endtask : pulse_scn
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		se_in = 4'h0;
		iso_in = 2'h0;
		diff_in = 2'h0;
		bus_in = 4'h0;
		mem_drain = 1'b0;
		fails = 0;
		comparisons = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		regs_scn();
		wr(`A_VWIN, 32'h0002_0001);
		wr(`A_HROI, 32'h0001_0001);
		wr(`A_VROI, 32'h0002_0000);
		wr(`A_THR, 32'h0016_0015);
		wr(`A_FMT, 32'h0);
		frame_scn(32'h0, 24'h000016, 24'h00001A);
		frame_scn(32'h4, `WHITE_8, 24'h000000);
		frame_scn(32'h8, 24'h000000, `WHITE_8);
		tap_scn();
		trig_scn();
		ctrl_scn();
		trig_start_scn();
		pulse_scn();
		print_verdict();
	end
endmodule : camera_link_acquisition_front_end_tb_top
